//--- core/cis_sequencer.sv
// interrupt latch, gating, priority and acceptance sequencer with apb registers
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
// Summary of operation
// - pending requests stay set until accepted, reset, or cleared by software
// - acceptance takes eight oscillator cycles after the current instruction ends
// - first acceptance step clears the global enable; break blocks all until return
// - the accepted source's pending flag is cleared during acceptance
// - return address and status word are pushed, stack pointer decremented three times
// - vector entry is read from the source's table slot and loaded into pc
// - return-from-interrupt ends the current service
// - nothing maskable is accepted while the global enable is zero
// - enable instruction inside service allows nesting of individually enabled sources
// - only pc and status are saved by hardware; software saves other registers
// - break trap is a software interrupt of the lowest priority
// - break shares the table call zero vector and sets the trap flag
// - higher priority wins; simultaneous requests resolved by fixed hardware order
// - external inputs are edge triggered, edge chosen by the edge select register
// - each edge detector offers rising, falling or both edges
// - edge select value 0000_0101 gives falling edge on both inputs
// - edges latch each cycle; a latched flag is evaluated three cycles later
// - an active acknowledged request makes the next operation a hardware call
// - at least twelve cycles from external activation to first service instruction
// - global enable is status bit 2 and gates all but reset and break
// - a source with its enable flag zero is never accepted
// - software reads and writes all source pending flags; the break pending flag is only readable
module cis_sequencer
  import cis_pkg::*;
#(
  parameter logic [15:0] BRK_VECTOR = CIS_VEC_TABLE_CALL_ZERO,
  parameter int DEPTH_W = 3
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external interrupt pins
  input wire logic ext_irq_a,
  input wire logic ext_irq_b,
  // internal source events, one-cycle pulses
  input wire logic timer_a_event,
  input wire logic timer_b_event,
  input wire logic converter_done_event,
  input wire logic watchdog_match_event,
  input wire logic interval_overflow_event,
  // cpu core instruction events, one-cycle pulses
  input wire logic instr_done,
  input wire logic enable_irq_instr,
  input wire logic disable_irq_instr,
  input wire logic break_trap_instr,
  input wire logic table_call_zero,
  input wire logic return_from_irq_instr,
  // cpu core context
  input wire logic [15:0] cpu_pc,
  input wire logic [7:0] cpu_psw,
  input wire logic [7:0] vec_data,
  // stack and vector requests toward the core
  output logic stack_push,
  output logic sp_dec,
  output logic [7:0] stack_data,
  output logic vec_rd,
  output logic [15:0] vec_addr,
  output logic pc_load,
  output logic [15:0] pc_value,
  output logic service_start,
  // flags
  output logic irq_flag,
  output logic brk_flag,
  output logic accept_busy
);
  import cis_pkg::*;

  localparam logic [7:0] IDX_MASK = 8'hff;

  cis_state_e state;
  logic [2:0] step;
  logic [CIS_NSRC-1:0] pending;
  logic [CIS_NSRC-1:0] enable;
  logic [7:0] edge_sel;
  logic brk_pending;
  logic nmi_hold;
  logic [DEPTH_W-1:0] depth;
  logic [CIS_NSRC-1:0] src_event;
  logic [CIS_NSRC-1:0] aged;
  logic [CIS_NREQ-1:0] eligible;
  logic [2:0] grant;
  logic grant_valid;
  logic [2:0] cur_src;
  logic saved_iflag;
  logic [15:0] saved_pc;
  logic [15:0] cur_vector;
  logic [7:0] vec_low;
  logic edge_a;
  logic edge_b;
  logic take;
  logic apb_setup;
  logic apb_write;
  logic [9:0] reg_idx;
  logic idx_ok;
  logic [CIS_NSRC-1:0] sw_pend_wr;
  logic [CIS_NSRC-1:0] sw_pend_val;
  logic [CIS_NSRC-1:0] next_pending;
  logic [7:0] rd_word;
  logic rd_ok;

  function automatic logic [15:0] vector_of(input logic [2:0] src);
    unique case (src)
      3'h0: vector_of = CIS_VEC_EXT_A;
      3'h1: vector_of = CIS_VEC_EXT_B;
      3'h2: vector_of = CIS_VEC_TIMER_A;
      3'h3: vector_of = CIS_VEC_TIMER_B;
      3'h4: vector_of = CIS_VEC_CONV;
      3'h5: vector_of = CIS_VEC_WDT;
      3'h6: vector_of = CIS_VEC_INTERVAL;
      3'h7: vector_of = BRK_VECTOR;
    endcase
  endfunction

  // external edges
  cis_edge_detect u_edge_a (
    .pclk(pclk),
    .presetn(presetn),
    .pin(ext_irq_a),
    .mode(cis_edge_e'(edge_sel[CIS_EDGE_A_LSB +: 2])),
    .edge_pulse(edge_a)
  );

  cis_edge_detect u_edge_b (
    .pclk(pclk),
    .presetn(presetn),
    .pin(ext_irq_b),
    .mode(cis_edge_e'(edge_sel[CIS_EDGE_B_LSB +: 2])),
    .edge_pulse(edge_b)
  );

  // source order fixes the rank: bit 0 highest
  assign src_event = {interval_overflow_event, watchdog_match_event, converter_done_event,
                      timer_b_event, timer_a_event, edge_b, edge_a};

  // apb decode
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pready && pwrite;
  assign reg_idx = paddr[11:2];
  assign idx_ok = (paddr[1:0] == 2'b00) && (reg_idx[9:8] == 2'b00);

  always_comb begin
    sw_pend_wr = '0;
    sw_pend_val = '0;
    if (apb_write && idx_ok && (reg_idx[7:0] == CIS_IDX_PENDING_HIGH)) begin
      sw_pend_wr[CIS_HIGH_SRCS-1:0] = '1;
      sw_pend_val[CIS_HIGH_SRCS-1:0] = pwdata[CIS_HIGH_SRCS-1:0];
    end
    if (apb_write && idx_ok && (reg_idx[7:0] == CIS_IDX_PENDING_LOW)) begin
      sw_pend_wr[CIS_NSRC-1:CIS_HIGH_SRCS] = '1;
      sw_pend_val[CIS_NSRC-1:CIS_HIGH_SRCS] = pwdata[CIS_NSRC-CIS_HIGH_SRCS-1:0];
    end
  end

  // per-source latch; a new event beats both software clear and acceptance clear
  always_comb begin
    next_pending = pending;
    for (int i = 0; i < CIS_NSRC; i++) begin
      if (sw_pend_wr[i]) begin
        next_pending[i] = sw_pend_val[i];
      end
      if (take && (grant == 3'(i))) begin
        next_pending[i] = 1'b0;
      end
      if (src_event[i]) begin
        next_pending[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending <= CIS_RST_PENDING;
    end else begin
      pending <= next_pending;
    end
  end

  // age of each request, so a fresh flag is never evaluated in its own cycle
  genvar g;
  generate
    for (g = 0; g < CIS_NSRC; g++) begin : g_age
      logic [3:0] age;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          age <= 4'h0;
        end else if (!pending[g] || src_event[g]) begin
          age <= 4'h0;
        end else if (age < 4'(CIS_RESP_WAIT)) begin
          age <= age + 4'h1;
        end
      end
      assign aged[g] = pending[g] && (age >= 4'(CIS_RESP_WAIT));
      assign eligible[g] = aged[g] && enable[g] && irq_flag && !nmi_hold;
    end
  endgenerate

  // break bypasses the enables but still waits behind everything else
  assign eligible[CIS_NREQ-1] = brk_pending && !nmi_hold;

  cis_priority #(
    .N(CIS_NREQ),
    .W(3)
  ) u_priority (
    .req(eligible),
    .grant(grant),
    .valid(grant_valid)
  );

  assign take = (state == CIS_ST_IDLE) && instr_done && grant_valid;

  // break request latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_pending <= 1'b0;
    end else if (break_trap_instr) begin
      brk_pending <= 1'b1;
    end else if (take && (grant == 3'h7)) begin
      brk_pending <= 1'b0;
    end
  end

  // trap source flag distinguishes break from an ordinary table call zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_flag <= 1'b0;
    end else if (take && (grant == 3'h7)) begin
      brk_flag <= 1'b1;
    end else if (table_call_zero) begin
      brk_flag <= 1'b0;
    end
  end

  // global enable flag, nmi hold and nesting depth
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flag <= 1'b0;
      nmi_hold <= 1'b0;
      depth <= '0;
    end else if (take) begin
      irq_flag <= 1'b0;
      nmi_hold <= (grant == 3'h7);
      depth <= depth + DEPTH_W'(1);
    end else if (return_from_irq_instr) begin
      irq_flag <= 1'b1;
      nmi_hold <= 1'b0;
      if (depth != '0) begin
        depth <= depth - DEPTH_W'(1);
      end
    end else if (enable_irq_instr) begin
      irq_flag <= 1'b1;
    end else if (disable_irq_instr) begin
      irq_flag <= 1'b0;
    end
  end

  // acceptance sequence: three pushes, two vector reads, load, start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= CIS_ST_IDLE;
      step <= 3'h0;
      cur_src <= 3'h0;
      saved_iflag <= 1'b0;
      saved_pc <= 16'h0000;
      cur_vector <= 16'h0000;
      vec_low <= 8'h00;
    end else begin
      unique case (state)
        CIS_ST_IDLE: begin
          step <= 3'h0;
          if (take) begin
            state <= CIS_ST_ACCEPT;
            cur_src <= grant;
            saved_iflag <= irq_flag;
            saved_pc <= cpu_pc;
            cur_vector <= vector_of(grant);
          end
        end
        CIS_ST_ACCEPT: begin
          step <= step + 3'h1;
          if (step == 3'h5) begin
            vec_low <= vec_data;
          end
          if (step == 3'(CIS_ACCEPT_CYCLES - 1)) begin
            state <= CIS_ST_IDLE;
          end
        end
      endcase
    end
  end

  // registered strobes toward the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_push <= 1'b0;
      sp_dec <= 1'b0;
      stack_data <= 8'h00;
      vec_rd <= 1'b0;
      vec_addr <= 16'h0000;
      pc_load <= 1'b0;
      pc_value <= 16'h0000;
      service_start <= 1'b0;
      accept_busy <= 1'b0;
    end else begin
      stack_push <= 1'b0;
      sp_dec <= 1'b0;
      vec_rd <= 1'b0;
      pc_load <= 1'b0;
      service_start <= 1'b0;
      accept_busy <= (state == CIS_ST_ACCEPT) && (step != 3'(CIS_ACCEPT_CYCLES - 1));
      if (state == CIS_ST_ACCEPT) begin
        unique case (step)
          3'h0: begin
            stack_push <= 1'b1;
            sp_dec <= 1'b1;
            stack_data <= saved_pc[15:8];
          end
          3'h1: begin
            stack_push <= 1'b1;
            sp_dec <= 1'b1;
            stack_data <= saved_pc[7:0];
          end
          3'h2: begin
            stack_push <= 1'b1;
            sp_dec <= 1'b1;
            stack_data <= {cpu_psw[7:CIS_PSW_BFLAG_BIT+1], brk_flag, cpu_psw[CIS_PSW_BFLAG_BIT-1:CIS_PSW_IFLAG_BIT+1],
                           saved_iflag, cpu_psw[CIS_PSW_IFLAG_BIT-1:0]};
          end
          3'h3: begin
            vec_rd <= 1'b1;
            vec_addr <= cur_vector;
          end
          3'h4: begin
            vec_rd <= 1'b1;
            vec_addr <= cur_vector + 16'h0001;
          end
          3'h5: begin
          end
          3'h6: begin
            pc_load <= 1'b1;
            pc_value <= {vec_data, vec_low};
          end
          3'h7: begin
            service_start <= 1'b1;
          end
        endcase
      end
    end
  end

  // enable and edge registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable <= CIS_RST_ENABLE[CIS_NSRC-1:0];
      edge_sel <= CIS_RST_EDGE;
    end else if (apb_write && idx_ok) begin
      if (reg_idx[7:0] == CIS_IDX_ENABLE_HIGH) begin
        enable[CIS_HIGH_SRCS-1:0] <= pwdata[CIS_HIGH_SRCS-1:0];
      end
      if (reg_idx[7:0] == CIS_IDX_ENABLE_LOW) begin
        enable[CIS_NSRC-1:CIS_HIGH_SRCS] <= pwdata[CIS_NSRC-CIS_HIGH_SRCS-1:0];
      end
      if (reg_idx[7:0] == CIS_IDX_EXT_EDGE_SELECT) begin
        edge_sel <= pwdata[7:0];
      end
    end
  end

  // read mux
  always_comb begin
    rd_word = 8'h00;
    rd_ok = idx_ok;
    unique case (reg_idx[7:0] & IDX_MASK)
      CIS_IDX_ENABLE_HIGH: rd_word = {4'h0, enable[CIS_HIGH_SRCS-1:0]};
      CIS_IDX_ENABLE_LOW: rd_word = {5'h00, enable[CIS_NSRC-1:CIS_HIGH_SRCS]};
      CIS_IDX_PENDING_HIGH: rd_word = {4'h0, pending[CIS_HIGH_SRCS-1:0]};
      CIS_IDX_PENDING_LOW: rd_word = {5'h00, pending[CIS_NSRC-1:CIS_HIGH_SRCS]};
      CIS_IDX_EXT_EDGE_SELECT: rd_word = edge_sel;
      CIS_IDX_STATUS: rd_word = {brk_pending, nmi_hold, state == CIS_ST_ACCEPT, brk_flag, depth[1:0], irq_flag, 1'b0};
      default: rd_ok = 1'b0;
    endcase
  end

  // zero wait states: answer is prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && !rd_ok;
      if (apb_setup && !pwrite && rd_ok) begin
        prdata <= {24'h000000, rd_word};
      end else if (apb_setup) begin
        prdata <= 32'h00000000;
      end
    end
  end
endmodule // cis_sequencer

//--- core/cis_pkg.sv
// constants, register map and types of the interrupt sequencer
package cis_pkg;
  localparam int CIS_NSRC = 7;
  localparam int CIS_NREQ = 8;
  // register indices; the byte address is four times the index
  localparam logic [7:0] CIS_IDX_ENABLE_HIGH = 8'he2;
  localparam logic [7:0] CIS_IDX_ENABLE_LOW = 8'he3;
  localparam logic [7:0] CIS_IDX_PENDING_HIGH = 8'he4;
  localparam logic [7:0] CIS_IDX_PENDING_LOW = 8'he5;
  localparam logic [7:0] CIS_IDX_EXT_EDGE_SELECT = 8'he6;
  localparam logic [7:0] CIS_IDX_STATUS = 8'he7;
  // reset values
  localparam logic [7:0] CIS_RST_ENABLE = 8'h00;
  localparam logic [7:0] CIS_RST_EDGE = 8'h00;
  localparam logic [CIS_NSRC-1:0] CIS_RST_PENDING = 7'h00;
  // field positions
  localparam int CIS_PSW_IFLAG_BIT = 2;
  localparam int CIS_PSW_BFLAG_BIT = 4;
  localparam int CIS_EDGE_A_LSB = 0;
  localparam int CIS_EDGE_B_LSB = 2;
  localparam int CIS_HIGH_SRCS = 4;
  // edge modes of the external inputs
  typedef enum logic [1:0] {
    CIS_EDGE_OFF = 2'b00,
    CIS_EDGE_FALL = 2'b01,
    CIS_EDGE_RISE = 2'b10,
    CIS_EDGE_BOTH = 2'b11
  } cis_edge_e;
  // timing, in oscillator periods of pclk; the clock period itself in ns
  localparam int CIS_CLK_PERIOD_NS = 10;
  localparam int CIS_ACCEPT_CYCLES = 8;
  localparam int CIS_RESP_MIN_CYCLES = 12;
  localparam int CIS_RESP_WAIT = CIS_RESP_MIN_CYCLES - CIS_ACCEPT_CYCLES - 1;
  // vectors, ranked from highest priority; slot 7 is the break trap
  localparam logic [15:0] CIS_VEC_EXT_A = 16'hfffa;
  localparam logic [15:0] CIS_VEC_EXT_B = 16'hfff8;
  localparam logic [15:0] CIS_VEC_TIMER_A = 16'hfff6;
  localparam logic [15:0] CIS_VEC_TIMER_B = 16'hfff4;
  localparam logic [15:0] CIS_VEC_CONV = 16'hffea;
  localparam logic [15:0] CIS_VEC_WDT = 16'hffe8;
  localparam logic [15:0] CIS_VEC_INTERVAL = 16'hffe6;
  localparam logic [15:0] CIS_VEC_TABLE_CALL_ZERO = 16'hffde;
  typedef enum logic {
    CIS_ST_IDLE = 1'b0,
    CIS_ST_ACCEPT = 1'b1
  } cis_state_e;
endpackage

//--- core/cis_edge_detect.sv
// synchronised edge detector for one external interrupt pin
`timescale 1ns/100ps
module cis_edge_detect
  import cis_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin and mode
  input wire logic pin,
  input wire cis_pkg::cis_edge_e mode,
  // detected edge, one cycle
  output logic edge_pulse
);
  logic sync1;
  logic sync2;
  logic sync3;
  logic stable;
  logic agree;

  assign agree = (sync2 == sync3);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // a change counts only once two samples agree, so one-cycle glitches are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable <= 1'b0;
      edge_pulse <= 1'b0;
    end else begin
      edge_pulse <= 1'b0;
      if (agree && (sync2 != stable)) begin
        stable <= sync2;
        unique case (mode)
          CIS_EDGE_OFF: edge_pulse <= 1'b0;
          CIS_EDGE_FALL: edge_pulse <= !sync2;
          CIS_EDGE_RISE: edge_pulse <= sync2;
          CIS_EDGE_BOTH: edge_pulse <= 1'b1;
        endcase
      end
    end
  end
endmodule // cis_edge_detect

//--- core/cis_priority.sv
// fixed priority picker, index 0 wins
`timescale 1ns/100ps
module cis_priority #(
  parameter int N = 8,
  parameter int W = 3
) (
  // requests
  input wire logic [N-1:0] req,
  // winner
  output logic [W-1:0] grant,
  output logic valid
);
  always_comb begin
    grant = '0;
    valid = 1'b0;
    // scan from lowest rank up so the highest rank overwrites last
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        grant = W'(i);
        valid = 1'b1;
      end
    end
  end
endmodule // cis_priority

//--- dv/cis_sequencer_props.sv
// concurrent checks on the interrupt sequencer ports
`timescale 1ns/100ps
module cis_sequencer_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // core side
  input wire logic enable_irq_instr,
  input wire logic return_from_irq_instr,
  input wire logic stack_push,
  input wire logic sp_dec,
  input wire logic vec_rd,
  input wire logic [15:0] vec_addr,
  input wire logic pc_load,
  input wire logic service_start,
  input wire logic irq_flag
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic mapped;
  assign mapped = paddr inside {12'h388, 12'h38c, 12'h390, 12'h394, 12'h398, 12'h39c};
  a_push_three: assert property ($rose(stack_push) |-> stack_push [*3] ##1 !stack_push)
    else $error("push burst not three long");
  a_push_dec: assert property (sp_dec == stack_push)
    else $error("stack pointer step not paired with push");
  a_vec_fetch: assert property ($rose(stack_push) |-> ##3 vec_rd [*2] ##1 !vec_rd)
    else $error("vector reads misplaced");
  a_vec_next: assert property ($rose(vec_rd) |=> vec_addr == $past(vec_addr) + 16'h0001)
    else $error("second vector read not at next byte");
  a_accept_len: assert property ($rose(stack_push) |-> ##6 pc_load ##1 service_start)
    else $error("acceptance not eight cycles");
  a_flag_low: assert property (stack_push |-> !irq_flag)
    else $error("global enable set while pushing");
  a_flag_cause: assert property ($rose(irq_flag) |-> $past(enable_irq_instr) || $past(return_from_irq_instr))
    else $error("global enable rose without cause");
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  a_err_map: assert property (psel && penable && pready |-> pslverr == !mapped)
    else $error("error response wrong for address");
  c_service: cover property ($rose(service_start));
  c_error: cover property (pslverr);
  c_enable: cover property ($rose(irq_flag));
endmodule // cis_sequencer_props
bind cis_sequencer cis_sequencer_props u_props (.*);

//--- dv/cis_core_model.sv
// behavioural cpu core answering stack and vector requests
`timescale 1ns/100ps
module cis_core_model #(
  parameter logic [7:0] CORE_PSW = 8'ha1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // requests from the sequencer
  input wire logic accept_busy,
  input wire logic stack_push,
  input wire logic [7:0] stack_data,
  input wire logic vec_rd,
  input wire logic [15:0] vec_addr,
  // core state
  output logic instr_done,
  output logic [15:0] cpu_pc,
  output logic [7:0] cpu_psw,
  output logic [7:0] vec_data,
  // observation
  output logic [15:0] taken_pc,
  output logic [23:0] pushed
);
  logic [1:0] icnt;
  logic [15:0] last_pc;
  // only pc and status are saved by hardware; the core keeps the rest itself
  assign cpu_psw = CORE_PSW;
  // an instruction ends every fourth cycle; the core stalls during a hardware call
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      icnt <= 2'h0;
      instr_done <= 1'b0;
      cpu_pc <= 16'h8000;
      last_pc <= 16'h0000;
    end else begin
      icnt <= icnt + 2'h1;
      instr_done <= (icnt == 2'h3) && !accept_busy;
      if (instr_done) begin
        cpu_pc <= cpu_pc + 16'h0003;
        last_pc <= cpu_pc;
      end
    end
  end
  // table byte valid one cycle after the read; otherwise the last byte is inverted every cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_data <= 8'h00;
    end else if (vec_rd) begin
      vec_data <= vec_addr[7:0] ^ 8'h3c;
    end else begin
      vec_data <= ~vec_data;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pushed <= 24'h000000;
      taken_pc <= 16'h0000;
    end else if (stack_push) begin
      pushed <= {pushed[15:0], stack_data};
      taken_pc <= last_pc;
    end
  end
endmodule // cis_core_model

//--- dv/cis_sequencer_tb_top.sv
// self-checking bench of the interrupt sequencer
`timescale 1ns/100ps
module cis_sequencer_tb_top;
  import cis_pkg::*;
  localparam logic [7:0] PSW0 = 8'ha1;
  localparam logic [7:0] PH = CIS_IDX_PENDING_HIGH;
  localparam logic [7:0] PL = CIS_IDX_PENDING_LOW;
  localparam logic [15:0] VEC [8] = '{CIS_VEC_EXT_A, CIS_VEC_EXT_B, CIS_VEC_TIMER_A, CIS_VEC_TIMER_B,
    CIS_VEC_CONV, CIS_VEC_WDT, CIS_VEC_INTERVAL, CIS_VEC_TABLE_CALL_ZERO};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] pins = 2'b00;
  // timer a, timer b, converter, watchdog, interval
  logic [4:0] src_ev = 5'h00;
  // enable, disable, break, table call zero, return
  logic [4:0] cpu_ev = 5'h00;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, stack_push, vec_rd, pc_load, service_start, irq_flag, brk_flag, accept_busy;
  logic instr_done;
  logic [15:0] cpu_pc, vec_addr, pc_value, taken_pc;
  logic [7:0] cpu_psw, vec_data, stack_data;
  logic [23:0] pushed;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  cis_sequencer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_irq_a(pins[0]), .ext_irq_b(pins[1]), .timer_a_event(src_ev[0]), .timer_b_event(src_ev[1]),
    .converter_done_event(src_ev[2]), .watchdog_match_event(src_ev[3]), .interval_overflow_event(src_ev[4]),
    .instr_done(instr_done), .enable_irq_instr(cpu_ev[0]), .disable_irq_instr(cpu_ev[1]),
    .break_trap_instr(cpu_ev[2]), .table_call_zero(cpu_ev[3]), .return_from_irq_instr(cpu_ev[4]),
    .cpu_pc(cpu_pc), .cpu_psw(cpu_psw), .vec_data(vec_data), .stack_push(stack_push), .sp_dec(),
    .stack_data(stack_data), .vec_rd(vec_rd), .vec_addr(vec_addr), .pc_load(pc_load), .pc_value(pc_value),
    .service_start(service_start), .irq_flag(irq_flag), .brk_flag(brk_flag), .accept_busy(accept_busy));
  cis_core_model #(.CORE_PSW(PSW0)) u_core (.pclk(pclk), .presetn(presetn), .accept_busy(accept_busy),
    .stack_push(stack_push), .stack_data(stack_data), .vec_rd(vec_rd), .vec_addr(vec_addr),
    .instr_done(instr_done), .cpu_pc(cpu_pc), .cpu_psw(cpu_psw), .vec_data(vec_data),
    .taken_pc(taken_pc), .pushed(pushed));
  initial begin
    forever #5 pclk = ~pclk;
  end
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // a hang ends the run as a mismatch
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] i, input logic [31:0] d);
    apb(1'b1, {2'b00, i, 2'b00}, d);
  endtask
  task rc(input logic [7:0] i, input logic [31:0] e);
    apb(1'b0, {2'b00, i, 2'b00}, 32'h0);
    chk(rd, e);
  endtask
  task cev(input int b);
    @(posedge pclk);
    cpu_ev[b] <= 1'b1;
    @(posedge pclk);
    cpu_ev <= 5'h00;
  endtask
  task sev(input logic [4:0] m);
    @(posedge pclk);
    src_ev <= m;
    @(posedge pclk);
    src_ev <= 5'h00;
  endtask
  task quiet(input int n);
    int c;
    c = 0;
    repeat (n) begin
      @(posedge pclk);
      if (pc_load === 1'b1) c++;
    end
    chk(c, 0);
  endtask
  // waits for the vector load and checks the entry address and the pushed context
  task wsvc(input int k, input logic ie, input logic be);
    int i;
    logic [7:0] b, h;
    // low byte sits at the vector address, high byte one above, so a swap is caught
    b = VEC[k][7:0] ^ 8'h3c;
    h = (VEC[k][7:0] + 8'h01) ^ 8'h3c;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pc_load !== 1'b1 && i < 400);
    chk(pc_load, 1'b1);
    chk(pc_value, {h, b});
    chk(pushed, {taken_pc, PSW0 | {3'b000, be, 1'b0, ie, 2'b00}});
  endtask
  initial begin
    logic [6:0] m;
    int t0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    for (int i = 2; i < 8; i++) rc(8'(8'he0 + i), 32'h0);
    apb(1'b0, 12'h3a0, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h389, 32'hff);
    chk(err, 1'b1);
    rc(CIS_IDX_ENABLE_HIGH, 32'h0);
    wr(PH, 32'h0f);
    rc(PH, 32'h0f);
    wr(PL, 32'h07);
    rc(PL, 32'h07);
    wr(PH, 32'h0);
    rc(PH, 32'h0);
    wr(PL, 32'h0);
    // off, falling, rising, both; mode written to both inputs at once
    for (int e = 0; e < 4; e++) begin
      wr(CIS_IDX_EXT_EDGE_SELECT, e * 5);
      rc(CIS_IDX_EXT_EDGE_SELECT, e * 5);
      pins <= 2'b11;
      repeat (8) @(posedge pclk);
      rc(PH, e[1] ? 32'h3 : 32'h0);
      wr(PH, 32'h0);
      pins <= 2'b00;
      repeat (8) @(posedge pclk);
      rc(PH, e[0] ? 32'h3 : 32'h0);
      wr(PH, 32'h0);
    end
    wr(CIS_IDX_EXT_EDGE_SELECT, 32'h0a);
    wr(CIS_IDX_ENABLE_HIGH, 32'h0f);
    wr(CIS_IDX_ENABLE_LOW, 32'h07);
    pins <= 2'b11;
    sev(5'h1f);
    quiet(20);
    cev(0);
    for (int k = 0; k < 7; k++) begin
      wsvc(k, 1'b1, 1'b0);
      m = 7'h7f << (k + 1);
      rc(PH, {28'h0, m[3:0]});
      rc(PL, {29'h0, m[6:4]});
      quiet(12);
      cev(k == 0 ? 0 : 4);
    end
    @(posedge pclk);
    chk(irq_flag, 1'b1);
    wr(CIS_IDX_ENABLE_LOW, 32'h0);
    sev(5'h1c);
    quiet(40);
    rc(PL, 32'h07);
    wr(PL, 32'h0);
    cev(1);
    sev(5'h02);
    repeat (6) @(posedge pclk);
    cpu_ev <= 5'h05;
    @(posedge pclk);
    cpu_ev <= 5'h00;
    wsvc(3, 1'b1, 1'b0);
    wsvc(7, 1'b0, 1'b1);
    chk(brk_flag, 1'b1);
    cev(0);
    sev(5'h01);
    quiet(20);
    cev(4);
    // the trap flag stays set until a table call zero clears it
    wsvc(2, 1'b1, 1'b1);
    cev(3);
    @(posedge pclk);
    chk(brk_flag, 1'b0);
    cev(4);
    cev(4);
    pins <= 2'b00;
    repeat (8) @(posedge pclk);
    t0 = cyc;
    pins <= 2'b01;
    wsvc(0, 1'b1, 1'b0);
    chk(cyc - t0 + 1 >= CIS_RESP_MIN_CYCLES, 1);
    cev(4);
    final_report();
  end
endmodule // cis_sequencer_tb_top
